// ### verilog/p2ei_pkg.sv
`default_nettype none
package p2ei_pkg;
  localparam int unsigned  REG_AW          = 8;
  localparam int unsigned  REG_DW          = 8;
  localparam int unsigned  PIN_CNT         = 8;
  localparam int unsigned  IRQ_PIN_CNT     = 4;
  localparam int unsigned  MODE_W          = 2;
  localparam int unsigned  EDGE_W          = 2;
  // Enabled edges after reset before the sampler's middle stage holds pin data
  localparam int unsigned  SYNC_FILL_EDGES = 2;
  // Register addresses, bank 1
  localparam logic [7:0]   ADDR_EDGE_CFG   = 8'he6;
  localparam logic [7:0]   ADDR_PULLUP_EN  = 8'he7;
  localparam logic [7:0]   RST_EDGE_CFG    = 8'h00;
  localparam logic [7:0]   RST_PULLUP_EN   = 8'h00;
  // Edge field codes
  localparam logic [1:0]   EDGE_OFF        = 2'h0;
  localparam logic [1:0]   EDGE_FALL       = 2'h1;
  localparam logic [1:0]   EDGE_RISE       = 2'h2;
  localparam logic [1:0]   EDGE_BOTH       = 2'h3;
  // Pin mode codes from the port control registers
  localparam logic [1:0]   MODE_SCHMITT_IN = 2'h0;
  localparam logic [1:0]   MODE_ALT_FUNC   = 2'h1;
  localparam logic [1:0]   MODE_OPEN_DRAIN = 2'h2;
  localparam logic [1:0]   MODE_PUSH_PULL  = 2'h3;
endpackage
`default_nettype wire

// ### verilog/p2ei_port2_ctrl.sv
// What this block does
// - Read/write edge config register at bank-1 0xe6, 2-bit field per pin 0..3, reset zero.
// - Field code 00 off, 01 falling, 10 rising, 11 both edges.
// - Read/write pull-up enable register at bank-1 0xe7, bit n for pin n, reset zero.
// - Pull-up forced off only while pin is push-pull output or alternate function.
`default_nettype none
module p2ei_port2_ctrl #(
  parameter int unsigned PIN_COUNT     = p2ei_pkg::PIN_CNT,     // Pins with a pull-up enable bit
  parameter int unsigned IRQ_PIN_COUNT = p2ei_pkg::IRQ_PIN_CNT  // Low pins with an edge field
) (
  input  wire logic                                         i_clk,              // 125 MHz clock
  input  wire logic                                         i_rst,              // Sync reset, active high
  input  wire logic                                         i_ce,               // Clock enable
  input  wire logic                                         i_reg_bank1,        // Register bank 1 selected
  input  wire logic [p2ei_pkg::REG_AW-1:0]                  i_reg_addr,         // Register address
  input  wire logic                                         i_reg_wr,           // Write strobe
  input  wire logic                                         i_reg_rd,           // Read strobe
  input  wire logic [p2ei_pkg::REG_DW-1:0]                  i_reg_wdata,        // Write data
  output logic      [p2ei_pkg::REG_DW-1:0]                  o_reg_rdata,        // Read data, one cycle later
  input  wire logic [p2ei_pkg::PIN_CNT*p2ei_pkg::MODE_W-1:0] i_pin_mode,        // Mode per pin, 2 bits each
  input  wire logic [p2ei_pkg::IRQ_PIN_CNT-1:0]             i_pin,              // Raw pin levels 0..3
  output logic      [p2ei_pkg::PIN_CNT-1:0]                 o_pullup_en,        // Effective pull-up per pin
  output logic                                              o_ext_irq_line_zero,  // Pin 0 edge pulse
  output logic                                              o_ext_irq_line_one,   // Pin 1 edge pulse
  output logic                                              o_ext_irq_line_two,   // Pin 2 edge pulse
  output logic                                              o_ext_irq_line_three  // Pin 3 edge pulse
);
  import p2ei_pkg::*;

  localparam int unsigned CFG_BITS  = IRQ_PIN_COUNT * EDGE_W;
  localparam logic [1:0]  FILL_LAST = 2'(SYNC_FILL_EDGES);

  // Port widths follow the package, so the parameters may only restate them
  if (PIN_COUNT != PIN_CNT) begin : g_chk_pins
    $error("PIN_COUNT must equal the pull-up port width");
  end

  if (IRQ_PIN_COUNT != IRQ_PIN_CNT) begin : g_chk_irq_pins
    $error("IRQ_PIN_COUNT must equal the pin input width");
  end

  if (PIN_COUNT > REG_DW) begin : g_chk_pullup_fit
    $error("pull-up bits do not fit one register");
  end

  if (CFG_BITS > REG_DW) begin : g_chk_cfg_fit
    $error("edge fields do not fit one register");
  end

  // Fill counter is two bits wide
  if (SYNC_FILL_EDGES > 3) begin : g_chk_fill
    $error("sampler fill count too large");
  end

  // Register storage
  logic [REG_DW-1:0]        port2_edge_irq_config;
  logic [REG_DW-1:0]        port2_pullup_enable;
  logic [REG_DW-1:0]        next_edge_cfg;
  logic [REG_DW-1:0]        next_pullup_reg;
  logic [REG_DW-1:0]        next_rdata_reg;

  // Pin sampler and edge reference
  logic [IRQ_PIN_CNT-1:0]   sync_a;
  logic [IRQ_PIN_CNT-1:0]   sync_b;
  logic [IRQ_PIN_CNT-1:0]   sync_c;
  logic [IRQ_PIN_CNT-1:0]   pin_level;
  logic [IRQ_PIN_CNT-1:0]   next_pin_level;
  logic [1:0]               fill_cnt;
  logic [1:0]               next_fill_cnt;
  logic                     primed;
  logic                     next_primed;

  // Output next values
  logic [PIN_CNT-1:0]       next_pullup;

  function automatic logic edge_hit(input logic [EDGE_W-1:0] sel, input logic rise, input logic fall);
    edge_hit = ((sel == EDGE_RISE) && rise) || ((sel == EDGE_FALL) && fall) ||
               ((sel == EDGE_BOTH) && (rise || fall));
  endfunction

  function automatic logic pullup_blocked(input logic [MODE_W-1:0] mode);
    pullup_blocked = (mode == MODE_PUSH_PULL) || (mode == MODE_ALT_FUNC);
  endfunction

  // Register decode
  wire logic                sel_edge    = i_reg_bank1 && (i_reg_addr == ADDR_EDGE_CFG);
  wire logic                sel_pullup  = i_reg_bank1 && (i_reg_addr == ADDR_PULLUP_EN);
  wire logic                wr_edge     = i_reg_wr && sel_edge;
  wire logic                wr_pullup   = i_reg_wr && sel_pullup;
  wire logic [REG_DW-1:0]   rd_mux      = sel_edge   ? port2_edge_irq_config :
                                          sel_pullup ? port2_pullup_enable   : 8'h00;

  assign next_edge_cfg   = wr_edge   ? i_reg_wdata : port2_edge_irq_config;
  assign next_pullup_reg = wr_pullup ? i_reg_wdata : port2_pullup_enable;
  // Read data holds until the next read strobe
  assign next_rdata_reg  = i_reg_rd  ? rd_mux      : o_reg_rdata;

  // Edge detection on the settled sampler output
  wire logic [IRQ_PIN_CNT-1:0] settled  = ~(sync_b ^ sync_c);
  wire logic [IRQ_PIN_CNT-1:0] changed  = {IRQ_PIN_CNT{primed}} & settled & (sync_c ^ pin_level);
  wire logic [IRQ_PIN_CNT-1:0] rising   = changed & sync_c;
  wire logic [IRQ_PIN_CNT-1:0] falling  = changed & ~sync_c;
  wire logic                   filled   = (fill_cnt == FILL_LAST);

  assign next_fill_cnt  = filled ? fill_cnt : fill_cnt + 2'h1;
  // Reference is armed only once real pin data sits in the middle stage and both compared stages agree,
  // so a pin already high at reset release is a level, not a rising edge
  assign next_primed    = primed || (filled && (&settled));
  assign next_pin_level = primed ? ((pin_level & ~settled) | (sync_c & settled)) : sync_c;

  wire logic [IRQ_PIN_CNT-1:0] next_irq;

  for (genvar g = 0; g < IRQ_PIN_CNT; g++) begin : g_edge
    assign next_irq[g] = edge_hit(port2_edge_irq_config[g*EDGE_W +: EDGE_W], rising[g], falling[g]);
  end

  // Pull-up gating per pin
  wire logic [PIN_CNT-1:0]  pin_blocked;

  for (genvar g = 0; g < PIN_CNT; g++) begin : g_pullup
    assign pin_blocked[g] = pullup_blocked(i_pin_mode[g*MODE_W +: MODE_W]);
  end

  assign next_pullup = port2_pullup_enable[PIN_CNT-1:0] & ~pin_blocked;

  // Registers and read data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port2_edge_irq_config <= RST_EDGE_CFG;
      port2_pullup_enable   <= RST_PULLUP_EN;
      o_reg_rdata           <= 8'h00;
    end else if (i_ce) begin
      port2_edge_irq_config <= next_edge_cfg;
      port2_pullup_enable   <= next_pullup_reg;
      o_reg_rdata           <= next_rdata_reg;
    end
  end

  // Three-stage sampler; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_c    <= '0;
      pin_level <= '0;
      fill_cnt  <= 2'h0;
      primed    <= 1'b0;
    end else if (i_ce) begin
      sync_a    <= i_pin;
      sync_b    <= sync_a;
      sync_c    <= sync_b;
      pin_level <= next_pin_level;
      fill_cnt  <= next_fill_cnt;
      primed    <= next_primed;
    end
  end

  // Effective pull-ups
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pullup_en <= 8'h00;
    end else if (i_ce) begin
      o_pullup_en <= next_pullup;
    end
  end

  // Interrupt request pulses, one enabled cycle each
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_irq_line_zero  <= 1'b0;
      o_ext_irq_line_one   <= 1'b0;
      o_ext_irq_line_two   <= 1'b0;
      o_ext_irq_line_three <= 1'b0;
    end else if (i_ce) begin
      o_ext_irq_line_zero  <= next_irq[0];
      o_ext_irq_line_one   <= next_irq[1];
      o_ext_irq_line_two   <= next_irq[2];
      o_ext_irq_line_three <= next_irq[3];
    end
  end

endmodule // p2ei_port2_ctrl
`default_nettype wire

// ### tb/p2ei_port2_ctrl_properties.sv
`default_nettype none
module p2ei_port2_ctrl_props (
  input wire logic        i_clk, i_rst, i_ce, i_reg_bank1, i_reg_wr, i_reg_rd,
  input wire logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_pullup_en,
  input wire logic [15:0] i_pin_mode,
  input wire logic [3:0]  i_pin,
  input wire logic        o_ext_irq_line_zero, o_ext_irq_line_one, o_ext_irq_line_two, o_ext_irq_line_three
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire       tk  = i_ce & i_reg_bank1;
  // Alt func and push-pull both carry bit 0 set
  wire [7:0] blk = {i_pin_mode[14], i_pin_mode[12], i_pin_mode[10], i_pin_mode[8],
                    i_pin_mode[6], i_pin_mode[4], i_pin_mode[2], i_pin_mode[0]};
  property rw(a);
    tk && i_reg_wr && i_reg_addr == a ##1 !i_reg_wr ##1 tk && i_reg_rd && i_reg_addr == a
      |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  AST_EDGE_RW: assert property (rw(8'he6)) else $error("edge config readback wrong");
  AST_PU_RW: assert property (rw(8'he7)) else $error("pull-up readback wrong");
  AST_PU_BLOCK: assert property (i_ce |=> !(o_pullup_en & $past(blk))) else $error("pull-up not off");
  AST_IRQ_ONE: assert property (o_ext_irq_line_zero && i_ce |=> !o_ext_irq_line_zero) else $error("pulse long");
  AST_IRQ_CAUSE: assert property (o_ext_irq_line_three |-> $past(i_pin[3], 4) != $past(i_pin[3], 5))
    else $error("pulse without edge");
  C_IRQ2: cover property (o_ext_irq_line_two);
  C_IRQ1: cover property (o_ext_irq_line_one);
  C_PU: cover property (|o_pullup_en);
endmodule // p2ei_port2_ctrl_props
bind p2ei_port2_ctrl p2ei_port2_ctrl_props p2ei_port2_ctrl_props_i (.*);
`default_nettype wire

// ### tb/test_port2_edge_irq_and_pullup_ctrl.sv
`default_nettype none
module test_port2_edge_irq_and_pullup_ctrl;
  timeunit 1ns; timeprecision 1ps;
  logic        i_clk = 0, i_rst = 1, i_ce = 1, i_reg_bank1 = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0]  i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata, o_pullup_en, b, d, pu = 0, e;
  logic [15:0] i_pin_mode = 0, m;
  logic [3:0]  i_pin = 0;
  logic        o_ext_irq_line_zero, o_ext_irq_line_one, o_ext_irq_line_two, o_ext_irq_line_three;
  int          failures = 0, cmp_count = 0, cnt[4] = '{0, 0, 0, 0};
  wire  [3:0]  irq = {o_ext_irq_line_three, o_ext_irq_line_two, o_ext_irq_line_one, o_ext_irq_line_zero};
  p2ei_port2_ctrl p2ei_port2_ctrl_i (.*);
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) for (int k = 0; k < 4; k++) cnt[k] += int'(irq[k]);
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Strobe drops after one edge; read data settles by the #1
  task automatic acc(input logic w, input logic bk, input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd, i_reg_bank1, i_reg_addr, i_reg_wdata} <= {w, !w, bk, a, v};
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd} <= 2'h0;
    #1;
  endtask
  task automatic end_of_test;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hd57df6c0));
    repeat (10) @(posedge i_clk);
    i_rst <= 0;
    for (int a = 'he5; a < 'he8; a++) begin
      acc(0, 1, 8'(a), 0);
      chk(o_reg_rdata, 8'h00);
    end
    for (int p = 0; p < 4; p++) for (int c = 0; c < 4; c++) begin
      d = 8'(c << (2 * p));
      acc(1, 1, 8'he6, d);
      acc(0, 1, 8'he6, 0);
      chk(o_reg_rdata, d);
      cnt = '{0, 0, 0, 0};
      @(posedge i_clk) i_pin[p] <= 1;
      repeat (8) @(posedge i_clk);
      i_pin[p] <= 0;
      repeat (8) @(posedge i_clk);
      #1 chk(8'(cnt[0] + 4 * cnt[1] + 16 * cnt[2] + 64 * cnt[3]), 8'(((c + 1) / 2) << (2 * p)));
    end
    // Mid-run reset with pins high: the refilled sampler must not see an edge
    i_pin <= 4'hf;
    repeat (6) @(posedge i_clk);
    i_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    acc(1, 1, 8'he6, 8'hff);
    cnt = '{0, 0, 0, 0};
    repeat (8) @(posedge i_clk);
    #1 chk(8'(cnt[0] + cnt[1] + cnt[2] + cnt[3]), 8'h00);
    // Clock enable low: a write must not land
    i_ce <= 0;
    acc(1, 1, 8'he7, 8'hff);
    i_ce <= 1;
    acc(0, 1, 8'he7, 0);
    chk(o_reg_rdata, 8'h00);
    repeat (24) begin
      b = 8'($urandom);
      d = 8'($urandom);
      m = 16'($urandom);
      i_pin_mode <= m;
      acc(1, b[0], 8'he7, d);
      if (b[0]) pu = d;
      acc(0, 1, 8'he7, 0);
      chk(o_reg_rdata, pu);
      for (int k = 0; k < 8; k++) e[k] = pu[k] & !m[2 * k];
      chk(o_pullup_en, e);
    end
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    end_of_test;
  end
endmodule // test_port2_edge_irq_and_pullup_ctrl
`default_nettype wire
